// File: src/iptc_regs.vh
// Register map, field positions and reset values of the interrupt block
`ifndef IPTC_REGS_VH
`define IPTC_REGS_VH
// Register byte offsets on the Avalon-MM slave
`define IPTC_OFS_STATUS 6'h00
`define IPTC_OFS_CORE 6'h04
`define IPTC_OFS_TRAP 6'h08
`define IPTC_OFS_FLAG 6'h10
`define IPTC_OFS_ENABLE 6'h14
`define IPTC_OFS_PRI0 6'h20
// CPU status word fields
`define IPTC_SR_IPL_LO 5
// Core control word fields
`define IPTC_CC_VAR 15
`define IPTC_CC_PRIORITY_LEVEL_EXTENSION 3
// Trap and nesting control fields
`define IPTC_TC_NEST_DIS 15
`define IPTC_TC_ACCA_OV 14
`define IPTC_TC_ACCB_OV 13
`define IPTC_TC_ACCA_CAT 12
`define IPTC_TC_ACCB_CAT 11
`define IPTC_TC_ACCA_TE 10
`define IPTC_TC_ACCB_TE 9
`define IPTC_TC_CAT_TE 8
`define IPTC_TC_SHIFT 7
`define IPTC_TC_DIV0 6
`define IPTC_TC_DMA 5
`define IPTC_TC_MATH 4
`define IPTC_TC_ADDR 3
// Implemented bits of the trap and nesting control word
`define IPTC_TC_WMASK 16'hfff8
// Reset values
`define IPTC_RST_WORD 16'h0000
`define IPTC_RST_IPL 3'h0
// Priority field that masks every user source
`define IPTC_IPL_ALL 3'h7
// Source priority fields sit one per nibble, four to a register
`define IPTC_PRI_PER_REG 4
`endif

// File: src/iptc_sync.v
// Two-stage synchroniser for the interrupt request inputs
`timescale 1ns/100ps
module iptc_sync #(
	parameter W = 16
) (
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Asynchronous levels in, synchronised levels out
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] stage1_r;

	// First stage feeds only the second stage
	always @(posedge CLK) begin
		if (SYS_RST) begin
			stage1_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			stage1_r <= d;
			q <= stage1_r;
		end
	end
endmodule // iptc_sync

// File: src/iptc_arb.v
// Priority resolver over the pending and enabled sources
`timescale 1ns/100ps
module iptc_arb #(
	parameter N = 16,
	parameter IW = 5
) (
	// Pending sources and their packed three-bit levels
	input wire [N-1:0] pend,
	input wire [3*N-1:0] pri,
	// Winning source
	output reg found,
	output reg [IW-1:0] win_idx,
	output reg [2:0] win_lvl
);
	integer i;

	// Scan from the top so that a lower number wins a tie
	always @* begin
		found = 1'b0;
		win_idx = {IW{1'b0}};
		win_lvl = 3'h0;
		for (i = N - 1; i >= 0; i = i - 1) begin
			// [RULE21] lowest number on ties
			if (pend[i] && pri[3*i +: 3] != 3'h0 &&
				pri[3*i +: 3] >= win_lvl) begin
				found = 1'b1;
				win_idx = i[IW-1:0];
				win_lvl = pri[3*i +: 3];
			end
		end
	end
endmodule // iptc_arb

// File: src/iptc_top.v
// Interrupt priority, nesting and trap status control with Avalon-MM
//
// Notes on behaviour
// [RULE1] Pending interrupt waits for instruction end
// [RULE2] Four program-space cases add one cycle
// [RULE3] One request flag per source, software clears
// [RULE4] Per-source enable bit gates forwarding
// [RULE5] Each source has eight-level programmable priority
// [RULE6] Fields allocated in ascending source order
// [RULE7] Status word bits 7..5 hold priority
// [RULE8] Field 111 is level 7, masks users
// [RULE9] Extension bit forms four-bit CPU priority
// [RULE10] Nesting disabled makes priority field read-only
// [RULE11] Extension bit only clearable by software
// [RULE12] Core control bit 15 selects latency mode
// [RULE13] Control bit 15 disables nesting
// [RULE14] Accumulator overflow trap status bits 14, 13
// [RULE15] Catastrophic overflow status bits 12, 11
// [RULE16] Bits 10, 9, 8 enable overflow traps
// [RULE17] Math trap sets bit 4, cause 7/6
// [RULE18] DMA trap bit 5, address trap bit 3
// [RULE19] Nesting disabled forces priority to 111
// [RULE20] Accepted source level loads CPU priority
// [RULE21] Equal priority: lowest source number wins
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "iptc_regs.vh"
module iptc_top #(
	parameter N_SRC = 16
) (
	// Clock and reset
	input wire CLK,
	input wire SYS_RST,
	// Avalon-MM slave
	input wire [5:0] ADDRESS,
	input wire READ,
	input wire WRITE,
	input wire [31:0] WRITEDATA,
	input wire [3:0] BYTEENABLE,
	output reg [31:0] READDATA,
	output reg WAITREQUEST,
	// Interrupt request lines from peripherals and pins
	input wire [N_SRC-1:0] SRC_REQ,
	// Trap causes, one-cycle pulses on CLK
	input wire ACC_A_OVF,
	input wire ACC_B_OVF,
	input wire ACC_A_CAT,
	input wire ACC_B_CAT,
	input wire SHIFT_ERR,
	input wire DIV_ZERO,
	input wire DMA_ERR,
	input wire ADDR_ERR,
	// CPU pipeline status
	input wire INSTR_END,
	input wire DW_MOVE_WINDOW,
	input wire STALL_TWO_CYCLE,
	input wire STALL_ONE_WINDOW,
	input wire BIT_SKIP_WINDOW,
	input wire RET_INT,
	input wire [3:0] RET_PRIORITY,
	// Exception requests and state toward the CPU
	output reg EXC_TAKE,
	output reg [4:0] EXC_VECTOR,
	output reg TRAP_REQ,
	output reg [3:0] CPU_PRIORITY,
	output reg LATENCY_VARIABLE,
	output reg NESTING_OFF
);
	localparam IW = 5;
	localparam ST_IDLE = 2'h0;
	localparam ST_EXTRA = 2'h1;

	// Byte enables widened to a 16-bit write mask
	function [15:0] be_mask;
		input [3:0] be;
		begin
			be_mask = {{8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	// Merge new data into a register under a mask
	function [15:0] merge;
		input [15:0] old;
		input [15:0] nw;
		input [15:0] m;
		begin
			merge = (old & ~m) | (nw & m);
		end
	endfunction

	// Word address decode
	function hit;
		input [5:0] a;
		input [5:0] ofs;
		begin
			hit = (a[5:2] == ofs[5:2]);
		end
	endfunction

	reg wait_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [2:0] ipl_r;
	reg [2:0] ipl_nxt;
	reg priority_level_extension_r;
	reg priority_level_extension_nxt;
	reg var_r;
	reg var_nxt;
	reg [15:0] trap_r;
	reg [15:0] trap_nxt;
	reg [N_SRC-1:0] flag_r;
	reg [N_SRC-1:0] flag_nxt;
	reg [N_SRC-1:0] en_r;
	reg [N_SRC-1:0] en_nxt;
	reg [3*N_SRC-1:0] pri_r;
	reg [3*N_SRC-1:0] pri_nxt;
	reg [N_SRC-1:0] req_prev_r;
	reg [IW-1:0] hold_idx_r;
	reg [2:0] hold_lvl_r;
	reg [31:0] rd_nxt;
	reg [15:0] tmp16;
	reg [15:0] set_tc;
	reg take_now;
	reg [IW-1:0] take_idx;
	reg [2:0] take_lvl;
	integer j;
	integer s;
	integer rj;
	integer rs;

	wire [N_SRC-1:0] req_sync;
	wire arb_found;
	wire [IW-1:0] arb_idx;
	wire [2:0] arb_lvl;
	wire [15:0] wmask;
	wire wr_ev;
	wire rd_start;
	wire trap_ev;
	wire extra_cycle;
	wire req_ok;
	wire nest_dis;
	wire [N_SRC-1:0] src_rise;

	// Request lines cross into the CPU clock domain
	iptc_sync #(
		.W(N_SRC)
	) u_sync (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.d(SRC_REQ),
		.q(req_sync)
	);

	// Resolve the highest pending enabled source
	iptc_arb #(
		.N(N_SRC),
		.IW(IW)
	) u_arb (
		// [RULE4] enable gates forwarding
		.pend(flag_r & en_r),
		.pri(pri_r),
		.found(arb_found),
		.win_idx(arb_idx),
		.win_lvl(arb_lvl)
	);

	// Bus strobes: a write commits when waitrequest is low
	assign wmask = be_mask(BYTEENABLE);
	assign wr_ev = WRITE & ~wait_r;
	assign rd_start = READ & wait_r;
	assign nest_dis = trap_r[`IPTC_TC_NEST_DIS];
	assign src_rise = req_sync & ~req_prev_r;

	// [RULE2] one added cycle in four cases
	assign extra_cycle = DW_MOVE_WINDOW | STALL_TWO_CYCLE |
		STALL_ONE_WINDOW | BIT_SKIP_WINDOW;

	// [RULE9] source must beat four-bit CPU priority
	assign req_ok = arb_found &&
		({1'b0, arb_lvl} > {priority_level_extension_r, ipl_r});

	// Trap events; only the overflow and catastrophic causes are gated by their enables
	always @* begin
		set_tc = `IPTC_RST_WORD;
		// [RULE16] overflow trap enables
		// [RULE14] accumulator overflow status
		set_tc[`IPTC_TC_ACCA_OV] = ACC_A_OVF &
			trap_r[`IPTC_TC_ACCA_TE];
		set_tc[`IPTC_TC_ACCB_OV] = ACC_B_OVF &
			trap_r[`IPTC_TC_ACCB_TE];
		// [RULE15] catastrophic overflow status
		set_tc[`IPTC_TC_ACCA_CAT] = ACC_A_CAT &
			trap_r[`IPTC_TC_CAT_TE];
		set_tc[`IPTC_TC_ACCB_CAT] = ACC_B_CAT &
			trap_r[`IPTC_TC_CAT_TE];
		// [RULE17] math trap and its cause
		set_tc[`IPTC_TC_SHIFT] = SHIFT_ERR;
		set_tc[`IPTC_TC_DIV0] = DIV_ZERO;
		set_tc[`IPTC_TC_MATH] = SHIFT_ERR | DIV_ZERO |
			(|set_tc[14:11]);
		// [RULE18] DMA and address trap status
		set_tc[`IPTC_TC_DMA] = DMA_ERR;
		set_tc[`IPTC_TC_ADDR] = ADDR_ERR;
	end

	assign trap_ev = |set_tc;

	// Entry sequencing: wait for an instruction boundary
	always @* begin
		state_nxt = state_r;
		take_now = 1'b0;
		take_idx = arb_idx;
		take_lvl = arb_lvl;
		case (state_r)
		ST_IDLE: begin
			// [RULE1] finish current instruction first
			if (req_ok && INSTR_END) begin
				if (extra_cycle) begin
					state_nxt = ST_EXTRA;
				end else begin
					take_now = 1'b1;
				end
			end
		end
		ST_EXTRA: begin
			// [RULE2] delayed entry by one cycle
			take_now = 1'b1;
			take_idx = hold_idx_r;
			take_lvl = hold_lvl_r;
			state_nxt = ST_IDLE;
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	// CPU priority level and its extension bit
	always @* begin
		ipl_nxt = ipl_r;
		priority_level_extension_nxt = priority_level_extension_r;
		// [RULE7] software writes priority field
		// [RULE10] ignored while nesting disabled
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_STATUS) &&
			wmask[7] && !nest_dis) begin
			ipl_nxt = WRITEDATA[7:5];
		end
		// [RULE11] extension only clearable
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_CORE) &&
			wmask[3] && !WRITEDATA[`IPTC_CC_PRIORITY_LEVEL_EXTENSION]) begin
			priority_level_extension_nxt = 1'b0;
		end
		// Return restores the stacked level
		if (RET_INT) begin
			priority_level_extension_nxt = RET_PRIORITY[3];
			ipl_nxt = RET_PRIORITY[2:0];
		end
		if (take_now) begin
			// [RULE19] force 111 when not nesting
			// [RULE20] load accepted source level
			// [RULE8] level 7 masks users
			ipl_nxt = nest_dis ? `IPTC_IPL_ALL : take_lvl;
		end
		// Traps lift the CPU above every user level
		if (trap_ev) begin
			priority_level_extension_nxt = 1'b1;
		end
	end

	// Core and trap control words
	always @* begin
		var_nxt = var_r;
		trap_nxt = trap_r;
		// [RULE12] latency mode select
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_CORE) &&
			wmask[15]) begin
			var_nxt = WRITEDATA[`IPTC_CC_VAR];
		end
		// [RULE13] nesting disable and trap bits
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_TRAP)) begin
			trap_nxt = merge(trap_r, WRITEDATA[15:0],
				wmask & `IPTC_TC_WMASK);
		end
		// Hardware set wins over a same-cycle clear
		trap_nxt = trap_nxt | set_tc;
	end

	// Flags, enables and priority arrays
	always @* begin
		tmp16 = `IPTC_RST_WORD;
		j = 0;
		s = 0;
		flag_nxt = flag_r;
		en_nxt = en_r;
		pri_nxt = pri_r;
		// [RULE3] flags cleared by software write
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_FLAG)) begin
			tmp16[N_SRC-1:0] = flag_r;
			tmp16 = merge(tmp16, WRITEDATA[15:0], wmask);
			flag_nxt = tmp16[N_SRC-1:0];
		end
		// [RULE3] request edge sets flag, set wins
		flag_nxt = flag_nxt | src_rise;
		// [RULE6] bit n belongs to source n
		if (wr_ev && hit(ADDRESS, `IPTC_OFS_ENABLE)) begin
			tmp16 = `IPTC_RST_WORD;
			tmp16[N_SRC-1:0] = en_r;
			tmp16 = merge(tmp16, WRITEDATA[15:0], wmask);
			en_nxt = tmp16[N_SRC-1:0];
		end
		// [RULE5] three-bit level per source
		// [RULE6] source 4k+j in nibble j of word k
		if (wr_ev && ADDRESS[5]) begin
			for (j = 0; j < `IPTC_PRI_PER_REG; j = j + 1) begin
				s = 4 * ADDRESS[4:2] + j;
				if (s < N_SRC && wmask[4*j]) begin
					pri_nxt[3*s +: 3] = WRITEDATA[4*j +: 3];
				end
			end
		end
	end

	// Read data for the addressed register
	always @* begin
		rd_nxt = 32'h0000_0000;
		rj = 0;
		rs = 0;
		if (hit(ADDRESS, `IPTC_OFS_STATUS)) begin
			rd_nxt[7:5] = ipl_r;
		end else if (hit(ADDRESS, `IPTC_OFS_CORE)) begin
			rd_nxt[`IPTC_CC_VAR] = var_r;
			rd_nxt[`IPTC_CC_PRIORITY_LEVEL_EXTENSION] = priority_level_extension_r;
		end else if (hit(ADDRESS, `IPTC_OFS_TRAP)) begin
			rd_nxt[15:0] = trap_r;
		end else if (hit(ADDRESS, `IPTC_OFS_FLAG)) begin
			rd_nxt[N_SRC-1:0] = flag_r;
		end else if (hit(ADDRESS, `IPTC_OFS_ENABLE)) begin
			rd_nxt[N_SRC-1:0] = en_r;
		end else if (ADDRESS[5]) begin
			for (rj = 0; rj < `IPTC_PRI_PER_REG; rj = rj + 1) begin
				rs = 4 * ADDRESS[4:2] + rj;
				if (rs < N_SRC) begin
					rd_nxt[4*rj +: 3] = pri_r[3*rs +: 3];
				end
			end
		end
	end

	// Bus handshake: one wait cycle on every access
	always @(posedge CLK) begin
		if (SYS_RST) begin
			wait_r <= 1'b1;
			WAITREQUEST <= 1'b1;
			READDATA <= 32'h0000_0000;
		end else begin
			wait_r <= ~((READ | WRITE) & wait_r);
			WAITREQUEST <= ~((READ | WRITE) & wait_r);
			if (rd_start) begin
				READDATA <= rd_nxt;
			end
		end
	end

	// Control and status state
	always @(posedge CLK) begin
		if (SYS_RST) begin
			state_r <= ST_IDLE;
			ipl_r <= `IPTC_RST_IPL;
			priority_level_extension_r <= 1'b0;
			var_r <= 1'b0;
			trap_r <= `IPTC_RST_WORD;
			flag_r <= {N_SRC{1'b0}};
			en_r <= {N_SRC{1'b0}};
			pri_r <= {3*N_SRC{1'b0}};
			req_prev_r <= {N_SRC{1'b0}};
			hold_idx_r <= {IW{1'b0}};
			hold_lvl_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			ipl_r <= ipl_nxt;
			priority_level_extension_r <= priority_level_extension_nxt;
			var_r <= var_nxt;
			trap_r <= trap_nxt;
			flag_r <= flag_nxt;
			en_r <= en_nxt;
			pri_r <= pri_nxt;
			req_prev_r <= req_sync;
			// Winner is frozen for the delayed entry
			if (state_r == ST_IDLE) begin
				hold_idx_r <= arb_idx;
				hold_lvl_r <= arb_lvl;
			end
		end
	end

	// Outputs toward the CPU, all registered
	always @(posedge CLK) begin
		if (SYS_RST) begin
			EXC_TAKE <= 1'b0;
			EXC_VECTOR <= 5'h00;
			TRAP_REQ <= 1'b0;
			CPU_PRIORITY <= 4'h0;
			LATENCY_VARIABLE <= 1'b0;
			NESTING_OFF <= 1'b0;
		end else begin
			EXC_TAKE <= take_now;
			if (take_now) begin
				EXC_VECTOR <= take_idx;
			end
			TRAP_REQ <= trap_ev;
			// [RULE9] extension above the three-bit field
			CPU_PRIORITY <= {priority_level_extension_nxt, ipl_nxt};
			LATENCY_VARIABLE <= var_nxt;
			NESTING_OFF <= trap_nxt[`IPTC_TC_NEST_DIS];
		end
	end
endmodule // iptc_top

// File: dv/iptc_cpu_model.sv
// Behavioural CPU pipeline model driving instruction-end and latency windows
`timescale 1ns/100ps
module iptc_cpu_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Flag program-space window cycles at instruction ends
	input wire logic slow,
	// Pipeline status toward the block
	output wire logic instr_end,
	output wire logic [3:0] win
);
	logic [3:0] cnt_r;
	// Free instruction counter; ends stay four cycles apart
	always @(posedge clk) begin
		if (sys_rst)
			cnt_r <= 4'h0;
		else
			cnt_r <= cnt_r + 4'h1;
	end
	assign instr_end = (cnt_r[1:0] == 2'h3);
	// four window cases
	// Rotate through the four cases at instruction ends while slow
	assign win = (slow && instr_end) ? (4'h1 << cnt_r[3:2]) : 4'h0;
endmodule // iptc_cpu_model

// File: dv/iptc_top_properties.sv
// Concurrent checks on the ports of the interrupt control block
`timescale 1ns/100ps
module iptc_props (
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Bus handshake
	input wire logic READ,
	input wire logic WRITE,
	input wire logic WAITREQUEST,
	// Trap causes and pipeline status
	input wire logic ACC_A_OVF,
	input wire logic ACC_B_OVF,
	input wire logic ACC_A_CAT,
	input wire logic ACC_B_CAT,
	input wire logic SHIFT_ERR,
	input wire logic DIV_ZERO,
	input wire logic DMA_ERR,
	input wire logic ADDR_ERR,
	input wire logic INSTR_END,
	input wire logic DW_MOVE_WINDOW,
	input wire logic STALL_TWO_CYCLE,
	input wire logic STALL_ONE_WINDOW,
	input wire logic BIT_SKIP_WINDOW,
	input wire logic RET_INT,
	input wire logic [3:0] RET_PRIORITY,
	// Outputs toward the CPU
	input wire logic EXC_TAKE,
	input wire logic [4:0] EXC_VECTOR,
	input wire logic TRAP_REQ,
	input wire logic [3:0] CPU_PRIORITY,
	input wire logic NESTING_OFF
);
	logic win;
	logic cause;
	// Any latency window, any trap cause
	assign win = DW_MOVE_WINDOW | STALL_TWO_CYCLE | STALL_ONE_WINDOW
		| BIT_SKIP_WINDOW;
	assign cause = ACC_A_OVF | ACC_B_OVF | ACC_A_CAT | ACC_B_CAT
		| SHIFT_ERR | DIV_ZERO | DMA_ERR | ADDR_ERR;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// One wait cycle per access
	bus_wait_a: assert property ((READ || WRITE) && WAITREQUEST
		|=> !WAITREQUEST ##1 WAITREQUEST) else $error("bad wait");
	entry_latency_a: assert property (EXC_TAKE |->
		($past(INSTR_END) && !$past(win)) || ($past(INSTR_END, 2)
		&& $past(win, 2))) else $error("entry latency wrong");
	trap_req_a: assert property (SHIFT_ERR || DIV_ZERO || DMA_ERR
		|| ADDR_ERR |=> TRAP_REQ) else $error("no trap request");
	ext_rise_a: assert property ($rose(CPU_PRIORITY[3]) |->
		$past(cause) || $past(RET_INT && RET_PRIORITY[3]))
		else $error("extension set without trap");
	nest_force_a: assert property (EXC_TAKE && NESTING_OFF |->
		CPU_PRIORITY[2:0] == 3'h7) else $error("priority not forced");
	vector_hold_a: assert property (!EXC_TAKE |-> $stable(EXC_VECTOR))
		else $error("vector moved");
	take_pulse_a: assert property (EXC_TAKE |=> !EXC_TAKE)
		else $error("entry repeated");
	level_mask_a: assert property ($past(CPU_PRIORITY) == 4'h7
		&& $past(CPU_PRIORITY, 2) == 4'h7 |-> !EXC_TAKE)
		else $error("entry at level 7");
	cover property (EXC_TAKE && NESTING_OFF);
	cover property (EXC_TAKE && $past(win, 2));
	cover property (TRAP_REQ && CPU_PRIORITY[3]);
endmodule // iptc_props
bind iptc_top iptc_props u_props (.CLK(CLK), .SYS_RST(SYS_RST),
	.READ(READ), .WRITE(WRITE), .WAITREQUEST(WAITREQUEST),
	.ACC_A_OVF(ACC_A_OVF), .ACC_B_OVF(ACC_B_OVF), .ACC_A_CAT(ACC_A_CAT),
	.ACC_B_CAT(ACC_B_CAT), .SHIFT_ERR(SHIFT_ERR), .DIV_ZERO(DIV_ZERO),
	.DMA_ERR(DMA_ERR), .ADDR_ERR(ADDR_ERR), .INSTR_END(INSTR_END),
	.DW_MOVE_WINDOW(DW_MOVE_WINDOW), .STALL_TWO_CYCLE(STALL_TWO_CYCLE),
	.STALL_ONE_WINDOW(STALL_ONE_WINDOW), .BIT_SKIP_WINDOW(BIT_SKIP_WINDOW),
	.RET_INT(RET_INT), .RET_PRIORITY(RET_PRIORITY), .EXC_TAKE(EXC_TAKE),
	.EXC_VECTOR(EXC_VECTOR), .TRAP_REQ(TRAP_REQ),
	.CPU_PRIORITY(CPU_PRIORITY), .NESTING_OFF(NESTING_OFF));

// File: dv/iptc_tb.sv
// Register and interrupt-entry tests for the interrupt control block
`timescale 1ns/100ps
`include "iptc_regs.vh"
module testbench;
	logic clk, sys_rst, read, write, ret_int, slow, instr_end, waitreq;
	logic exc_take, trap_req, lat_var, nest_off;
	logic [5:0] address;
	logic [15:0] wdata, rdat, src_req;
	logic [31:0] rdata;
	logic [7:0] trap_v;
	logic [3:0] win, cpu_pri;
	logic [4:0] exc_vec;
	logic [15:0] tbl [0:7];
	integer fails, cmp_count, i;
	iptc_top u_dut (.CLK(clk), .SYS_RST(sys_rst), .ADDRESS(address),
		.READ(read), .WRITE(write), .WRITEDATA({16'h0000, wdata}),
		.BYTEENABLE(4'h3), .READDATA(rdata), .WAITREQUEST(waitreq),
		.SRC_REQ(src_req), .ACC_A_OVF(trap_v[0]), .ACC_B_OVF(trap_v[1]),
		.ACC_A_CAT(trap_v[2]), .ACC_B_CAT(trap_v[3]), .SHIFT_ERR(trap_v[4]),
		.DIV_ZERO(trap_v[5]), .DMA_ERR(trap_v[6]), .ADDR_ERR(trap_v[7]),
		.INSTR_END(instr_end), .DW_MOVE_WINDOW(win[0]),
		.STALL_TWO_CYCLE(win[1]), .STALL_ONE_WINDOW(win[2]),
		.BIT_SKIP_WINDOW(win[3]), .RET_INT(ret_int), .RET_PRIORITY(4'h0),
		.EXC_TAKE(exc_take), .EXC_VECTOR(exc_vec), .TRAP_REQ(trap_req),
		.CPU_PRIORITY(cpu_pri), .LATENCY_VARIABLE(lat_var),
		.NESTING_OFF(nest_off));
	iptc_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .slow(slow),
		.instr_end(instr_end), .win(win));
	// Clock at 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, fails);
			if (fails == 0 && cmp_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		begin
			cmp_count++;
			if (got !== exp) begin
				fails++;
				$display("mismatch at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	// One bus access, held until waitrequest is sampled low
	task acc(input logic w, input logic [5:0] a, input logic [15:0] d);
		begin
			@(posedge clk);
			address <= a;
			wdata <= d;
			write <= w;
			read <= !w;
			@(posedge clk);
			while (waitreq !== 1'b0) @(posedge clk);
			rdat = rdata[15:0];
			write <= 1'b0;
			read <= 1'b0;
		end
	endtask
	task rd(input logic [5:0] a, input logic [15:0] e);
		begin
			acc(1'b0, a, 16'h0000);
			chk(rdat, e);
		end
	endtask
	task pulse_ret;
		begin
			@(posedge clk);
			ret_int <= 1'b1;
			@(posedge clk);
			ret_int <= 1'b0;
		end
	endtask
	// Wait for an entry, then check vector and new priority
	task wt(input logic [4:0] v, input logic [3:0] p);
		integer k;
		begin
			k = 0;
			@(negedge clk);
			while (exc_take !== 1'b1 && k < 60) begin
				@(negedge clk);
				k = k + 1;
			end
			chk({exc_take, 6'h00, exc_vec, cpu_pri}, {1'b1, 6'h00, v, p});
		end
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#300000;
		fails++;
		print_verdict();
	end
	initial begin
		tbl = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050,
			16'h0020, 16'h0008};
		fails = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		wdata = 16'h0000;
		src_req = 16'h0000;
		trap_v = 8'h00;
		ret_int = 1'b0;
		slow = 1'b0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`IPTC_OFS_STATUS, 16'h0000);
		rd(`IPTC_OFS_CORE, 16'h0000);
		rd(`IPTC_OFS_TRAP, 16'h0000);
		acc(1'b1, 6'h3c, 16'hffff);
		rd(6'h3c, 16'h0000);
		acc(1'b1, `IPTC_OFS_STATUS, 16'h0060);
		rd(`IPTC_OFS_STATUS, 16'h0060);
		acc(1'b1, `IPTC_OFS_TRAP, 16'h8700);
		rd(`IPTC_OFS_TRAP, 16'h8700);
		acc(1'b1, `IPTC_OFS_STATUS, 16'h00a0);
		rd(`IPTC_OFS_STATUS, 16'h0060);
		acc(1'b1, `IPTC_OFS_TRAP, 16'h0700);
		acc(1'b1, `IPTC_OFS_CORE, 16'h8008);
		rd(`IPTC_OFS_CORE, 16'h8000);
		chk({15'h0000, lat_var}, 16'h0001);
		$display("register test done");
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			trap_v <= 8'h01 << i;
			@(posedge clk);
			trap_v <= 8'h00;
			@(negedge clk);
			chk({15'h0000, trap_req}, 16'h0001);
			rd(`IPTC_OFS_TRAP, 16'h0700 | tbl[i]);
			rd(`IPTC_OFS_CORE, 16'h8008);
			chk({12'h000, cpu_pri}, 16'h000b);
			acc(1'b1, `IPTC_OFS_TRAP, 16'h0700);
			acc(1'b1, `IPTC_OFS_CORE, 16'h8000);
		end
		// Overflow causes with their enables off leave no trace
		acc(1'b1, `IPTC_OFS_TRAP, 16'h0000);
		@(posedge clk);
		trap_v <= 8'h0f;
		@(posedge clk);
		trap_v <= 8'h00;
		@(negedge clk);
		chk({15'h0000, trap_req}, 16'h0000);
		rd(`IPTC_OFS_TRAP, 16'h0000);
		$display("trap test done");
		acc(1'b1, `IPTC_OFS_STATUS, 16'h0000);
		acc(1'b1, `IPTC_OFS_PRI0, 16'h6550);
		acc(1'b1, `IPTC_OFS_ENABLE, 16'h0006);
		@(posedge clk);
		src_req <= 16'h000e;
		wt(5'h01, 4'h5);
		rd(`IPTC_OFS_FLAG, 16'h000e);
		acc(1'b1, `IPTC_OFS_FLAG, 16'h000c);
		slow <= 1'b1;
		pulse_ret();
		wt(5'h02, 4'h5);
		@(posedge clk);
		slow <= 1'b0;
		src_req <= 16'h0000;
		acc(1'b1, `IPTC_OFS_FLAG, 16'h0000);
		pulse_ret();
		acc(1'b1, `IPTC_OFS_TRAP, 16'h8000);
		@(posedge clk);
		src_req <= 16'h0002;
		wt(5'h01, 4'h7);
		chk({15'h0000, nest_off}, 16'h0001);
		$display("entry test done");
		print_verdict();
	end
endmodule // testbench
